/* rtl/comap_pkg.sv */
// Package of the current output address map: area bases, field layout,
// analogue thresholds, watchdog timing and the request/answer carriers.
// Assumes a single 125 MHz core clock shared by every user of the package.
package comap_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned WDG_TRIP_MS     = 500;
   localparam int unsigned WDG_TRIP_CYC    = (CLK_HZ / 1000) * WDG_TRIP_MS;
   localparam int unsigned WDG_FAIL_LIMIT  = 3;

   // ****************************************************************
   // Area bases, zero-based and numbered legacy scheme
   // ****************************************************************
   localparam logic [15:0] STAT_BIT_BASE_ZB  = 16'h0800;  // 2048
   localparam logic [15:0] STAT_BIT_BASE_NL  = 16'h36B1;  // 14001
   localparam logic [15:0] STAT_WORD_BASE_ZB = 16'h0300;  // 768
   localparam logic [15:0] STAT_WORD_BASE_NL = 16'h8980;  // 35200
   localparam logic [15:0] KIND_WORD_BASE_ZB = 16'h0400;  // 1024
   localparam logic [15:0] KIND_WORD_BASE_NL = 16'h89E4;  // 35300
   localparam logic [15:0] AUX_BASE_ZB       = 16'h0800;  // 2048
   localparam logic [15:0] AUX_BASE_NL       = 16'h8B74;  // 35700
   localparam logic [15:0] OUT_ALLOC_BASE_ZB = 16'h0000;  // 0
   localparam logic [15:0] OUT_ALLOC_BASE_NL = 16'h9C41;  // 40001
   localparam logic [15:0] OUT_SLOT_BASE_ZB  = 16'h0100;  // 256
   localparam logic [15:0] OUT_SLOT_BASE_NL  = 16'hAFC8;  // 45000

   localparam logic [15:0] STAT_BIT_STRIDE   = 16'h0008;
   localparam logic [15:0] AUX_STRIDE        = 16'h000C;
   localparam int unsigned AUX_WORDS         = 12;

   // ****************************************************************
   // Function and exception codes
   // ****************************************************************
   localparam logic [7:0] FC_READ_BITS   = 8'h02;
   localparam logic [7:0] FC_READ_HOLD   = 8'h03;
   localparam logic [7:0] FC_READ_INPUT  = 8'h04;
   localparam logic [7:0] FC_WRITE_ONE   = 8'h06;
   localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
   localparam logic [7:0] EXC_ILL_FUNC   = 8'h01;
   localparam logic [7:0] EXC_ILL_ADDR   = 8'h02;

   // ****************************************************************
   // Field layout and reset values
   // ****************************************************************
   localparam int unsigned OUT_INVALID_BIT = 1;
   localparam int unsigned OUT_VALUE_LSB   = 4;
   localparam int unsigned STAT_LB_BIT     = 8;
   localparam int unsigned STAT_WDG_BIT    = 9;
   localparam int unsigned STAT_INV_BIT    = 10;
   localparam logic [15:0] OUT_WORD_RST    = 16'h0000;
   localparam logic [15:0] KIND_WORD_VAL   = 16'h00A5;  // Arbitrary value.

   // ****************************************************************
   // Analogue thresholds, 12-bit codes over a 0 to 25 mA span
   // ****************************************************************
   localparam int unsigned SPAN_UA       = 25_000;
   localparam int unsigned MIN_DRIVE_UA  = 1_000;
   localparam int unsigned BREAK_UA      = 100;
   localparam logic [11:0] MIN_DRIVE_CODE =
      12'((MIN_DRIVE_UA * 4095 + SPAN_UA - 1) / SPAN_UA);
   localparam logic [11:0] BREAK_CODE =
      12'((BREAK_UA * 4095) / SPAN_UA);

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic        valid;
      logic        legacy;   // 1: numbered legacy scheme.
      logic [7:0]  func;
      logic [15:0] addr;
      logic [15:0] wdata;
   } comap_req_t;

   typedef struct packed {
      logic        valid;
      logic        exc;
      logic [7:0]  exc_code;
      logic [15:0] rdata;
   } comap_rsp_t;

endpackage : comap_pkg

/* rtl/comap_top.sv */
// Slot-based address map and supervision of a one-channel current output.
// Assumes requests come one word at a time from a protocol front end on
// core_clk_i, and that the measured current and configuration inputs are
// already synchronous to core_clk_i.
//
// Overview of operation
// - Every area has one zero-based and one numbered legacy base.
// - Status bits are read singly by function 2 at base + 8*slot + bit.
// - Status and kind words are read by function 4 at base plus slot.
// - Aux variables, field-protocol variant only, sit at base + 12*slot.
// - The output word is written by function 6 or 16, read by function 3.
// - Line-break detection exists and is switched on per channel.
// - With detection on and the output not switched off, at least 1 mA flows even when 0 mA is commanded.
// - With detection on and the output not switched off, a current below 0.1 mA reports a lead breakage.
// - The output goes off 500 ms after three failed exchanges in a row.
// - Only successive failures count; a good exchange restarts the count.
// - The process value travels as one unsigned 16-bit word.
// - Output word bit 1 is the invalid flag, bits 4 to 15 the 12-bit value.
// - The invalid status bit is dropped when scaling lies outside 10000 to 50000.
module comap_top #(
   parameter logic        HAS_AUX  = 1'b1,
   parameter int unsigned TRIP_CYC = comap_pkg::WDG_TRIP_CYC
) (
   input  wire logic                   core_clk_i,
   input  wire logic                   rst_n_i,
   input  wire comap_pkg::comap_req_t  req_i,
   output comap_pkg::comap_rsp_t       rsp_o,
   input  wire logic [7:0]             slot_i,
   input  wire logic [7:0]             alloc_pos_i,
   input  wire logic                   lb_enable_i,
   input  wire logic                   scale_in_range_i,
   input  wire logic [11:0]            meas_code_i,
   input  wire logic                   aux_wr_i,
   input  wire logic [3:0]             aux_idx_i,
   input  wire logic [15:0]            aux_data_i,
   input  wire logic                   comm_ok_i,
   input  wire logic                   comm_fail_i,
   output logic [11:0]                 drive_code_o,
   output logic                        line_break_o,
   output logic                        output_off_o
);
   import comap_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      comap_rsp_t                       rsp;
      logic [15:0]                      out_word;
      logic [AUX_WORDS-1:0][15:0]       aux;
      logic [11:0]                      drive;
      logic                             lbreak;
      logic                             off;
   } comap_state_t;

   comap_state_t st_reg;
   comap_state_t st_next;
   logic         wdg_off;

   // Returns whether addr lies in [base, base+span); off gives its offset above base.
   function automatic logic in_area(input logic [15:0] addr,
                                    input logic [15:0] base,
                                    input logic [15:0] span,
                                    output logic [15:0] off);
      logic [16:0] diff;
      diff = {1'b0, addr} - {1'b0, base};
      off  = diff[15:0];
      return !diff[16] && (diff[15:0] < span);
   endfunction : in_area

   function automatic logic [15:0] pick(input logic legacy,
                                        input logic [15:0] zb,
                                        input logic [15:0] nl);
      return legacy ? nl : zb;
   endfunction : pick

   // ****************************************************************
   // Watchdog
   // ****************************************************************
   comap_watchdog #(
      .TRIP_CYC    (TRIP_CYC)
   ) u_wdg (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .comm_ok_i   (comm_ok_i),
      .comm_fail_i (comm_fail_i),
      .off_o       (wdg_off)
   );

   // ****************************************************************
   // Decode and supervision
   // ****************************************************************
   always_comb
   begin
      logic [15:0] off;
      logic [15:0] stat_word;
      logic [15:0] bit_start;
      logic [15:0] aux_start;
      logic [15:0] slot_w;
      logic [15:0] alloc_w;
      logic        hit;
      logic        fc_ok;
      logic [15:0] rd;
      logic        wr;
      logic        invalid;
      logic [11:0] cmd;

      off       = 16'h0;
      stat_word = 16'h0;
      invalid   = 1'b0;
      cmd       = 12'h000;
      slot_w    = {8'h00, slot_i};
      alloc_w   = {8'h00, alloc_pos_i};
      bit_start = pick(req_i.legacy, STAT_BIT_BASE_ZB, STAT_BIT_BASE_NL)
                  + 16'(slot_w * STAT_BIT_STRIDE);
      aux_start = pick(req_i.legacy, AUX_BASE_ZB, AUX_BASE_NL)
                  + 16'(slot_w * AUX_STRIDE);
      hit       = 1'b0;
      fc_ok     = 1'b0;
      rd        = 16'h0;
      wr        = 1'b0;
      st_next   = st_reg;

      // The invalid flag only exists when the scaling leaves room for it.
      invalid = scale_in_range_i && st_reg.out_word[OUT_INVALID_BIT];
      stat_word[STAT_LB_BIT]  = st_reg.lbreak;
      stat_word[STAT_WDG_BIT] = st_reg.off;
      stat_word[STAT_INV_BIT] = invalid;

      // Function 2 and the aux area share a zero-based base; the function
      // code separates them, so bits are tried first only for function 2.
      if (req_i.func == FC_READ_BITS &&
          in_area(req_i.addr, bit_start, STAT_BIT_STRIDE, off))
      begin
         hit   = 1'b1;
         fc_ok = 1'b1;
         rd    = {15'h0, stat_word[STAT_LB_BIT + 32'(off[2:0])]};
      end
      else if (in_area(req_i.addr,
                       pick(req_i.legacy, STAT_WORD_BASE_ZB,
                            STAT_WORD_BASE_NL) + slot_w, 16'h1, off))
      begin
         hit   = 1'b1;
         fc_ok = (req_i.func == FC_READ_INPUT);
         rd    = stat_word;
      end
      else if (in_area(req_i.addr,
                       pick(req_i.legacy, KIND_WORD_BASE_ZB,
                            KIND_WORD_BASE_NL) + slot_w, 16'h1, off))
      begin
         hit   = 1'b1;
         fc_ok = (req_i.func == FC_READ_INPUT);
         rd    = KIND_WORD_VAL;
      end
      else if (HAS_AUX && req_i.func != FC_READ_BITS &&
               in_area(req_i.addr, aux_start, AUX_STRIDE, off))
      begin
         hit   = 1'b1;
         fc_ok = (req_i.func == FC_READ_INPUT);
         rd    = st_reg.aux[off[3:0]];
      end
      else if (in_area(req_i.addr,
                       pick(req_i.legacy, OUT_ALLOC_BASE_ZB,
                            OUT_ALLOC_BASE_NL) + alloc_w, 16'h1, off) ||
               in_area(req_i.addr,
                       pick(req_i.legacy, OUT_SLOT_BASE_ZB,
                            OUT_SLOT_BASE_NL) + alloc_w, 16'h1, off))
      begin
         hit   = 1'b1;
         fc_ok = (req_i.func == FC_READ_HOLD) ||
                 (req_i.func == FC_WRITE_ONE) ||
                 (req_i.func == FC_WRITE_MULTI);
         wr    = (req_i.func != FC_READ_HOLD);
         rd    = st_reg.out_word;
      end

      st_next.rsp = '0;
      if (req_i.valid)
      begin
         st_next.rsp.valid = 1'b1;
         if (!hit)
         begin
            st_next.rsp.exc      = 1'b1;
            st_next.rsp.exc_code = EXC_ILL_ADDR;
         end
         else if (!fc_ok)
         begin
            st_next.rsp.exc      = 1'b1;
            st_next.rsp.exc_code = EXC_ILL_FUNC;
         end
         else if (wr)
         begin
            st_next.out_word  = req_i.wdata;
            st_next.rsp.rdata = req_i.wdata;
         end
         else
         begin
            st_next.rsp.rdata = rd;
         end
      end

      if (aux_wr_i && 32'(aux_idx_i) < AUX_WORDS)
      begin
         st_next.aux[aux_idx_i] = aux_data_i;
      end

      // The DAC takes the upper 12 bits; the low nibble is status only.
      cmd = st_reg.out_word[15:OUT_VALUE_LSB];
      if (lb_enable_i && cmd < MIN_DRIVE_CODE)
      begin
         cmd = MIN_DRIVE_CODE;
      end
      st_next.off    = wdg_off;
      st_next.drive  = wdg_off ? 12'h000 : cmd;
      // A breakage cannot be told from a switched-off output, so the
      // check is held off while the watchdog has the output down.
      st_next.lbreak = lb_enable_i && !wdg_off &&
                       (meas_code_i < BREAK_CODE);
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         st_reg          <= '0;
         st_reg.out_word <= OUT_WORD_RST;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign rsp_o        = st_reg.rsp;
   assign drive_code_o = st_reg.drive;
   assign line_break_o = st_reg.lbreak;
   assign output_off_o = st_reg.off;

endmodule : comap_top

/* rtl/comap_watchdog.sv */
// Communication watchdog: counts successive failed exchanges with the
// communication unit and switches the output off after a fixed delay.
// Assumes fail and success strobes are one-cycle pulses on core_clk_i.
module comap_watchdog #(
   parameter int unsigned TRIP_CYC = comap_pkg::WDG_TRIP_CYC
) (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic comm_ok_i,
   input  wire logic comm_fail_i,
   output logic      off_o
);
   import comap_pkg::*;

   typedef struct packed {
      logic [1:0]  fails;
      logic        armed;
      logic [31:0] cnt;
      logic        off;
   } comap_wdg_state_t;

   comap_wdg_state_t st_reg;
   comap_wdg_state_t st_next;

   always_comb
   begin
      st_next = st_reg;
      if (comm_ok_i)
      begin
         // A good exchange restarts the count and clears the trip.
         st_next.fails = 2'h0;
         st_next.armed = 1'b0;
         st_next.cnt   = 32'h0;
         st_next.off   = 1'b0;
      end
      else if (comm_fail_i && !st_reg.armed)
      begin
         if (32'(st_reg.fails) + 32'h1 >= 32'(WDG_FAIL_LIMIT))
         begin
            st_next.armed = 1'b1;
            st_next.cnt   = 32'h0;
         end
         else
         begin
            st_next.fails = st_reg.fails + 2'h1;
         end
      end
      if (st_reg.armed && !st_reg.off && !comm_ok_i)
      begin
         if (st_reg.cnt >= 32'(TRIP_CYC - 1))
         begin
            st_next.off = 1'b1;
         end
         else
         begin
            st_next.cnt = st_reg.cnt + 32'h1;
         end
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign off_o = st_reg.off;

endmodule : comap_watchdog

/* testbench/comap_master_model.sv */
// Model of the bus master that issues one word request at a time.
// Assumes the answer stands for the one cycle after the request edge.
module comap_master_model (
   input  wire logic                  core_clk_i,
   input  wire comap_pkg::comap_rsp_t rsp_i,
   output comap_pkg::comap_req_t      req_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import comap_pkg::*;
   initial req_o = '0;
   // A gap lets the master be slow; released fields are scrambled so
   // that nothing relies on stale values.
   task automatic xfer(input logic lg, input logic [7:0] fc,
      input logic [15:0] ad, input logic [15:0] wd, input int gap,
      output comap_rsp_t r);
      repeat (gap + 1) @(posedge core_clk_i);
      #1;
      req_o = '{1'h1, lg, fc, ad, wd};
      @(posedge core_clk_i);
      #1;
      r = rsp_i;
      req_o = '{1'h0, ~lg, ~fc, ~ad, ~wd};
   endtask : xfer
endmodule : comap_master_model

/* testbench/comap_top_assertions.sv */
// Checker for the current output address map, on comap_top ports only.
// Assumes one clock domain with a synchronous active-low reset.
module comap_top_assertions #(
   parameter int unsigned TRIP_CYC = 20
) (
   input wire logic                  core_clk_i,
   input wire logic                  rst_n_i,
   input wire comap_pkg::comap_req_t req_i,
   input wire comap_pkg::comap_rsp_t rsp_o,
   input wire logic [7:0]            slot_i,
   input wire logic [7:0]            alloc_pos_i,
   input wire logic                  lb_enable_i,
   input wire logic [11:0]           meas_code_i,
   input wire logic                  comm_ok_i,
   input wire logic                  comm_fail_i,
   input wire logic [11:0]           drive_code_o,
   input wire logic                  line_break_o,
   input wire logic                  output_off_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import comap_pkg::*;
   // ****************************************************************
   // Watchdog reference: successive failures and time since arming
   // ****************************************************************
   logic [1:0]  fails_reg;
   logic        armed_reg;
   logic [31:0] tmr_reg;
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_n_i || comm_ok_i)
      begin
         fails_reg <= 2'h0;
         armed_reg <= 1'h0;
         tmr_reg   <= 32'h0;
      end
      else if (armed_reg)
         tmr_reg <= tmr_reg + 32'h1;
      else if (comm_fail_i && fails_reg == 2'h2)
      begin
         armed_reg <= 1'h1;
         tmr_reg   <= 32'h1;
      end
      else if (comm_fail_i)
         fails_reg <= fails_reg + 2'h1;
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   logic zb;
   assign zb = req_i.valid && !req_i.legacy;
   // ****************************************************************
   // Assertions
   // ****************************************************************
   chk_rsp_timing: assert property (req_i.valid |=> rsp_o.valid)
      else $error("answer missing one cycle after a request");
   chk_rsp_spur: assert property (!req_i.valid |=> !rsp_o.valid)
      else $error("answer without a request");
   chk_kind_read: assert property (zb && req_i.func == FC_READ_INPUT
      && req_i.addr == KIND_WORD_BASE_ZB + {8'h00, slot_i}
      |=> !rsp_o.exc && rsp_o.rdata == KIND_WORD_VAL)
      else $error("kind word read wrong");
   chk_write_echo: assert property (zb && req_i.func == FC_WRITE_ONE
      && req_i.addr == OUT_SLOT_BASE_ZB + {8'h00, alloc_pos_i}
      |=> !rsp_o.exc && rsp_o.rdata == $past(req_i.wdata))
      else $error("output word write not echoed");
   chk_ro_refuse: assert property (zb && req_i.func == FC_WRITE_ONE
      && req_i.addr == STAT_WORD_BASE_ZB + {8'h00, slot_i}
      |=> rsp_o.exc && rsp_o.exc_code == EXC_ILL_FUNC)
      else $error("write to status word not refused");
   chk_min_drive: assert property ((lb_enable_i && !output_off_o)[*3]
      |=> output_off_o || drive_code_o >= MIN_DRIVE_CODE)
      else $error("drive below minimum with detection on");
   chk_break_flag: assert property ((lb_enable_i && !output_off_o
      && meas_code_i < BREAK_CODE)[*2] |=> line_break_o || output_off_o)
      else $error("lead breakage not reported");
   chk_lb_disabled: assert property (!lb_enable_i |=> !line_break_o)
      else $error("breakage reported with detection off");
   chk_wdg_trip: assert property ($rose(output_off_o)
      |-> armed_reg && tmr_reg == TRIP_CYC + 2)
      else $error("output switched off at the wrong time");
   chk_wdg_clear: assert property (comm_ok_i |-> ##2 !output_off_o)
      else $error("good exchange did not release the output");
   cover property (req_i.valid && req_i.func == FC_WRITE_MULTI);
   cover property ($rose(line_break_o));
   cover property ($rose(output_off_o));
endmodule : comap_top_assertions

bind comap_top comap_top_assertions #(.TRIP_CYC(TRIP_CYC)) u_chk (
   .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .req_i(req_i),
   .rsp_o(rsp_o), .slot_i(slot_i), .alloc_pos_i(alloc_pos_i),
   .lb_enable_i(lb_enable_i), .meas_code_i(meas_code_i),
   .comm_ok_i(comm_ok_i), .comm_fail_i(comm_fail_i),
   .drive_code_o(drive_code_o), .line_break_o(line_break_o),
   .output_off_o(output_off_o));

/* testbench/comap_top_tb_top.sv */
// Self-checking bench of the current output address map.
// Assumes the master model and the bound checker; watchdog shortened.
module comap_top_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import comap_pkg::*;
   localparam int unsigned TRIP = 20;
   localparam logic [15:0] S = 16'h0003;
   localparam logic [15:0] P = 16'h0002;
   typedef struct packed {
      logic lg; logic [7:0] fc; logic [15:0] ad; logic [15:0] wd;
      logic ex; logic [7:0] cd; logic [15:0] rd;
   } comap_row_t;
   logic core_clk = 1'h0;
   logic rst_n, lb_en, scale_ok, aux_wr, comm_ok, comm_fail, lbrk, off;
   logic [11:0] meas, drive;
   logic [3:0]  aux_idx;
   logic [15:0] aux_data;
   comap_req_t  req;
   comap_rsp_t  rsp, r;
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          n;
   comap_row_t  rows [15];
   always #4 core_clk = ~core_clk;
   comap_master_model u_mst (.core_clk_i(core_clk), .rsp_i(rsp),
      .req_o(req));
   comap_top #(.HAS_AUX(1'h1), .TRIP_CYC(TRIP)) u_dut (
      .core_clk_i(core_clk), .rst_n_i(rst_n), .req_i(req), .rsp_o(rsp),
      .slot_i(S[7:0]), .alloc_pos_i(P[7:0]), .lb_enable_i(lb_en),
      .scale_in_range_i(scale_ok), .meas_code_i(meas), .aux_wr_i(aux_wr),
      .aux_idx_i(aux_idx), .aux_data_i(aux_data), .comm_ok_i(comm_ok),
      .comm_fail_i(comm_fail), .drive_code_o(drive),
      .line_break_o(lbrk), .output_off_o(off));
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk_w
   task automatic rd(input logic lg, input logic [7:0] fc,
      input logic [15:0] ad, input logic [15:0] exp);
      u_mst.xfer(lg, fc, ad, 16'h0000, 0, r);
      chk_w(r.rdata, exp);
   endtask : rd
   task automatic wr(input logic [15:0] wd);
      u_mst.xfer(1'h0, FC_WRITE_ONE, OUT_SLOT_BASE_ZB + P, wd, 0, r);
      tick(1);
   endtask : wr
   task automatic stop_test;
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test
   initial
   begin
      rows = '{
         '{0, FC_WRITE_ONE, OUT_SLOT_BASE_ZB + P, 16'h5A32, 0, 0, 16'h5A32},
         '{1, FC_READ_HOLD, OUT_SLOT_BASE_NL + P, 0, 0, 0, 16'h5A32},
         '{1, FC_WRITE_MULTI, OUT_ALLOC_BASE_NL + P, 16'h1230, 0, 0, 16'h1230},
         '{0, FC_READ_HOLD, OUT_ALLOC_BASE_ZB + P, 0, 0, 0, 16'h1230},
         '{0, FC_READ_INPUT, KIND_WORD_BASE_ZB + S, 0, 0, 0, KIND_WORD_VAL},
         '{1, FC_READ_INPUT, KIND_WORD_BASE_NL + S, 0, 0, 0, KIND_WORD_VAL},
         '{0, FC_READ_INPUT, STAT_WORD_BASE_ZB + S, 0, 0, 0, 16'h0000},
         '{1, FC_READ_INPUT, STAT_WORD_BASE_NL + S, 0, 0, 0, 16'h0000},
         '{0, FC_READ_INPUT, AUX_BASE_ZB + AUX_STRIDE * S, 0, 0, 0, 16'hBEEF},
         '{1, FC_READ_INPUT, AUX_BASE_NL + AUX_STRIDE * S + 16'h000B, 0, 0, 0,
           16'h1357},
         '{0, FC_READ_INPUT, OUT_SLOT_BASE_ZB + P, 0, 1, EXC_ILL_FUNC, 0},
         '{0, FC_READ_HOLD, 16'h0200, 0, 1, EXC_ILL_ADDR, 0},
         '{0, FC_WRITE_ONE, STAT_WORD_BASE_ZB + S, 16'h1111, 1, EXC_ILL_FUNC, 0},
         '{0, 8'h05, OUT_SLOT_BASE_ZB + P, 0, 1, EXC_ILL_FUNC, 0},
         '{0, FC_READ_HOLD, OUT_SLOT_BASE_ZB + P, 0, 0, 0, 16'h1230}};
      {rst_n, lb_en, aux_wr, comm_ok, comm_fail} = '0;
      scale_ok = 1'h1;
      meas = 12'h800;
      aux_idx = 4'h0;
      aux_data = 16'hBEEF;
      repeat (12) @(posedge core_clk);
      #1;
      rst_n = 1'h1;
      aux_wr = 1'h1;
      tick(1);
      aux_idx = 4'hB;
      aux_data = 16'h1357;
      tick(1);
      aux_wr = 1'h0;
      foreach (rows[i])
      begin
         u_mst.xfer(rows[i].lg, rows[i].fc, rows[i].ad, rows[i].wd, i % 2, r);
         chk_w({15'h0000, r.valid}, 16'h0001);
         chk_w({15'h0000, r.exc}, {15'h0000, rows[i].ex});
         if (rows[i].ex)
            chk_w({8'h00, r.exc_code}, {8'h00, rows[i].cd});
         else
            chk_w(r.rdata, rows[i].rd);
      end
      wr(16'h8000);
      chk_w({4'h0, drive}, 16'h0800);
      lb_en = 1'h1;
      wr(16'h0000);
      chk_w({4'h0, drive}, {4'h0, MIN_DRIVE_CODE});
      wr(16'h0A50);
      chk_w({4'h0, drive}, 16'h00A5);
      wr(16'h0A30);
      chk_w({4'h0, drive}, {4'h0, MIN_DRIVE_CODE});
      lb_en = 1'h0;
      wr(16'h0000);
      chk_w({4'h0, drive}, 16'h0000);
      wr(16'h0012);
      rd(0, FC_READ_INPUT, STAT_WORD_BASE_ZB + S, 16'h0400);
      rd(0, FC_READ_BITS, STAT_BIT_BASE_ZB + 16'h001A, 16'h0001);
      rd(1, FC_READ_BITS, STAT_BIT_BASE_NL + 16'h001A, 16'h0001);
      scale_ok = 1'h0;
      rd(0, FC_READ_BITS, STAT_BIT_BASE_ZB + 16'h001A, 16'h0000);
      lb_en = 1'h1;
      meas = 12'h010;
      tick(3);
      chk_w({15'h0000, lbrk}, 16'h0000);
      meas = 12'h00F;
      tick(3);
      chk_w({15'h0000, lbrk}, 16'h0001);
      rd(0, FC_READ_BITS, STAT_BIT_BASE_ZB + 16'h0018, 16'h0001);
      lb_en = 1'h0;
      tick(3);
      chk_w({15'h0000, lbrk}, 16'h0000);
      meas = 12'h800;
      wr(16'h8000);
      for (n = 0; n < 5; n++)
      begin
         comm_ok = (n == 2);
         comm_fail = (n != 2);
         tick(1);
         {comm_ok, comm_fail} = 2'h0;
         tick(1);
      end
      tick(TRIP + 5);
      chk_w({15'h0000, off}, 16'h0000);
      comm_fail = 1'h1;
      tick(1);
      comm_fail = 1'h0;
      for (n = 1; n < TRIP + 10 && off !== 1'h1; n++)
         tick(1);
      chk_w(16'(n - 1), 16'(TRIP + 1));
      tick(2);
      chk_w({4'h0, drive}, 16'h0000);
      rd(0, FC_READ_BITS, STAT_BIT_BASE_ZB + 16'h0019, 16'h0001);
      comm_ok = 1'h1;
      tick(1);
      comm_ok = 1'h0;
      tick(2);
      chk_w({15'h0000, off}, 16'h0000);
      rst_n = 1'h0;
      tick(2);
      chk_w({15'h0000, rsp.valid}, 16'h0000);
      rst_n = 1'h1;
      rd(0, FC_READ_HOLD, OUT_SLOT_BASE_ZB + P, 16'h0000);
      stop_test();
   end
endmodule : comap_top_tb_top
